/* hw/chan_trigger.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - basic mode uses the primary level, crossing in selected direction.
// - dual mode runs both comparators; fire above upper or below lower.
// - inverted directions in dual mode fire on re-entering the window.
// - dual mode forces secondary direction opposite to primary.
// - dual mode applies one hysteresis value to both comparators.
// - qualifier mode routes detector output to a qualifier input.
// - qualifier variants use the basic or dual levels but arm while beyond them, not on a crossing.
// - all channel triggers are OR-combined into the recorder trigger.
// - any enabled qualifier not armed suppresses the recorder trigger.
// - external trigger input uses one common rising-or-falling edge select.
// - per-card enable lets external trigger input act as a source.
// - external trigger output polarity is one shared setting.
// - per-card enable forwards recorder trigger to the external output.
// - recorder trigger is offered to other recorders and mainframes.
// - single-level alarm holds while signal is beyond the level.
// - dual-level alarm holds while signal is beyond either level.
// - channel alarms OR together with others onto one alarm output.
// - trigger on first sample strictly beyond the level; equal does not.
// - signal already beyond level at start does not fire.
// - re-arm only after leaving the hysteresis band, then new crossing.
// - each channel independently off, trigger, qualifier or alarm.

`include "trig_map.svh"

module chan_trigger
  import trig_pkg::*;
#(
  parameter int N_CH = 4,
  parameter int W    = SAMPLE_W
) (
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  // sample stream
  input  wire logic                       run_i,
  input  wire logic                       smp_valid_i,
  input  wire logic signed [N_CH-1:0][W-1:0] smp_i,
  // configuration
  input  wire ch_cfg_t     [N_CH-1:0]     ch_cfg_i,
  input  wire rec_cfg_t                   rec_cfg_i,
  // external and shared triggers, alarm chain input
  input  wire logic                       ext_trig_i,
  input  wire logic                       share_trig_i,
  input  wire logic                       alarm_chain_i,
  // results
  output logic             [N_CH-1:0]     ch_trig_o,
  output logic             [N_CH-1:0]     qual_armed_o,
  output logic                            rec_trig_o,
  output logic                            share_trig_o,
  output logic                            ext_trig_o,
  output logic                            alarm_o
);

  //////////////////////////////////////////////////////////////////////////////

  logic [N_CH-1:0] ch_hit;
  logic [N_CH-1:0] qual_hit;
  logic [N_CH-1:0] qual_en;
  logic [N_CH-1:0] alarm_lvl;
  logic [N_CH-1:0] ch_trig_r;
  logic [N_CH-1:0] qual_r;
  logic [N_CH-1:0] alarm_r;

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    ch_mode_t mode;
    logic     dual_use;
    logic     sec_dir;
    logic     p_cross;
    logic     p_beyond;
    logic     s_cross;
    logic     s_beyond;
    logic     c_en;

    assign mode     = ch_cfg_i[c].mode;
    assign c_en     = run_i && (mode != MODE_OFF);
    assign dual_use = (mode == MODE_DUAL) || (mode == MODE_QUAL_2)
                   || (mode == MODE_ALARM_2);
    assign sec_dir  = ~ch_cfg_i[c].dir;

    level_cmp #(.W(W)) u_prim (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .run_i       (c_en),
      .smp_valid_i (smp_valid_i),
      .smp_i       (smp_i[c]),
      .level_i     (ch_cfg_i[c].prim_level),
      .hyst_i      (ch_cfg_i[c].hyst),
      .dir_i       (ch_cfg_i[c].dir),
      .cross_o     (p_cross),
      .beyond_o    (p_beyond)
    );

    // same hysteresis on both levels; runs only in the dual variants
    level_cmp #(.W(W)) u_sec (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .run_i       (c_en && dual_use),
      .smp_valid_i (smp_valid_i),
      .smp_i       (smp_i[c]),
      .level_i     (ch_cfg_i[c].sec_level),
      .hyst_i      (ch_cfg_i[c].hyst),
      .dir_i       (sec_dir),
      .cross_o     (s_cross),
      .beyond_o    (s_beyond)
    );

    // inverted slopes turn exit detection into window re-entry
    always_comb begin
      ch_hit[c]    = 1'b0;
      qual_hit[c]  = 1'b0;
      alarm_lvl[c] = 1'b0;
      qual_en[c]   = 1'b0;
      case (mode)
        MODE_BASIC:   ch_hit[c] = p_cross;
        MODE_DUAL:    ch_hit[c] = p_cross || s_cross;
        // levels hold between sample strobes; idle bus data is not a sample
        MODE_QUAL_1: begin
          qual_en[c]  = 1'b1;
          qual_hit[c] = smp_valid_i ? p_beyond : qual_r[c];
        end
        MODE_QUAL_2: begin
          qual_en[c]  = 1'b1;
          qual_hit[c] = smp_valid_i ? (p_beyond || s_beyond) : qual_r[c];
        end
        MODE_ALARM_1: alarm_lvl[c] = run_i && (smp_valid_i ? p_beyond : alarm_r[c]);
        MODE_ALARM_2: alarm_lvl[c] = run_i && (smp_valid_i ? (p_beyond || s_beyond)
                                                           : alarm_r[c]);
        default:      ch_hit[c] = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered per-channel results

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ch_trig_r <= '0;
    end else begin
      ch_trig_r <= ch_hit;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      qual_r <= '0;
    end else begin
      qual_r <= qual_hit;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      alarm_r <= '0;
    end else begin
      alarm_r <= alarm_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // external trigger input edge

  logic ext_prev_r;
  logic ext_edge;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ext_prev_r <= `EXT_LEVEL_RST;
    end else begin
      ext_prev_r <= ext_trig_i;
    end
  end

  assign ext_edge = rec_cfg_i.ext_in_falling ? (ext_prev_r && !ext_trig_i)
                                             : (!ext_prev_r && ext_trig_i);

  //////////////////////////////////////////////////////////////////////////////
  // combine

  logic qual_ok;
  logic src_any;
  logic qual_en_r;
  logic rec_trig_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      qual_en_r <= 1'b0;
    end else begin
      qual_en_r <= 1'b1;
    end
  end

  // every enabled qualifier must be armed
  assign qual_ok = &(qual_r | ~qual_en) && qual_en_r;
  assign src_any = (|ch_trig_r)
                || (rec_cfg_i.ext_in_en && ext_edge)
                || share_trig_i;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rec_trig_r <= 1'b0;
    end else begin
      rec_trig_r <= run_i && src_any && qual_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  logic ext_out_r;
  logic alarm_out_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ext_out_r <= 1'b0;
    end else begin
      ext_out_r <= rec_cfg_i.ext_out_en && rec_trig_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      alarm_out_r <= 1'b0;
    end else begin
      alarm_out_r <= (|alarm_r) || alarm_chain_i;
    end
  end

  assign ch_trig_o    = ch_trig_r;
  assign qual_armed_o = qual_r;
  assign rec_trig_o   = rec_trig_r;
  assign share_trig_o = rec_trig_r;
  assign ext_trig_o   = ext_out_r ^ rec_cfg_i.ext_out_active_low;
  assign alarm_o      = alarm_out_r;

endmodule // chan_trigger

`default_nettype wire

/* hw/trig_map.svh */
`ifndef TRIG_MAP_SVH
`define TRIG_MAP_SVH

// channel mode encodings
`define CH_MODE_OFF      3'h0
`define CH_MODE_BASIC    3'h1
`define CH_MODE_DUAL     3'h2
`define CH_MODE_QUAL_1   3'h3
`define CH_MODE_QUAL_2   3'h4
`define CH_MODE_ALARM_1  3'h5
`define CH_MODE_ALARM_2  3'h6

// direction encodings
`define DIR_POS          1'b0
`define DIR_NEG          1'b1

// reset values
`define CH_CFG_RST       '0
`define EXT_LEVEL_RST    1'b0

`endif

/* hw/trig_pkg.sv */
package trig_pkg;

  localparam int SAMPLE_W = 16;

  typedef enum logic [2:0] {
    MODE_OFF     = 3'b000,
    MODE_BASIC   = 3'b001,
    MODE_DUAL    = 3'b010,
    MODE_QUAL_1  = 3'b011,
    MODE_QUAL_2  = 3'b100,
    MODE_ALARM_1 = 3'b101,
    MODE_ALARM_2 = 3'b110
  } ch_mode_t;

  // per-channel configuration
  typedef struct packed {
    ch_mode_t                    mode;
    logic                        dir;
    logic signed [SAMPLE_W-1:0]  prim_level;
    logic signed [SAMPLE_W-1:0]  sec_level;
    logic        [SAMPLE_W-1:0]  hyst;
  } ch_cfg_t;

  // recorder-wide settings; ext edge and out polarity are mainframe-wide
  typedef struct packed {
    logic ext_in_en;
    logic ext_in_falling;
    logic ext_out_en;
    logic ext_out_active_low;
  } rec_cfg_t;

endpackage

/* hw/level_cmp.sv */
`timescale 1ns/1ps
`default_nettype none

`include "trig_map.svh"

module level_cmp
  import trig_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // sample stream
  input  wire logic                run_i,
  input  wire logic                smp_valid_i,
  input  wire logic signed [W-1:0] smp_i,
  // setting
  input  wire logic signed [W-1:0] level_i,
  input  wire logic        [W-1:0] hyst_i,
  input  wire logic                dir_i,
  // results
  output logic                     cross_o,
  output logic                     beyond_o
);

  logic signed [W+1:0] lvl_x;
  logic signed [W+1:0] arm_x;
  logic signed [W+1:0] smp_x;
  logic                past_arm;
  logic                armed_r;

  assign lvl_x = {{2{level_i[W-1]}}, level_i};
  assign smp_x = {{2{smp_i[W-1]}}, smp_i};
  // re-arm point sits the hysteresis below (pos) or above (neg) the level
  assign arm_x = (dir_i == `DIR_POS) ? lvl_x - $signed({2'b00, hyst_i})
                                     : lvl_x + $signed({2'b00, hyst_i});

  // strictly beyond the level; equal does not count
  assign beyond_o = (dir_i == `DIR_POS) ? (smp_x > lvl_x) : (smp_x < lvl_x);

  // at or on the arming side of the hysteresis band
  assign past_arm = (dir_i == `DIR_POS) ? (smp_x <= arm_x) : (smp_x >= arm_x);

  // armed only after a sample on the near side; starting beyond never fires
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !run_i) begin
      armed_r <= 1'b0;
    end else if (smp_valid_i) begin
      if (armed_r && beyond_o) begin
        armed_r <= 1'b0;
      end else if (past_arm && !beyond_o) begin
        armed_r <= 1'b1;
      end
    end
  end

  assign cross_o = run_i && smp_valid_i && armed_r && beyond_o;

endmodule // level_cmp

`default_nettype wire

/* tb/trig_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module trig_properties
  import trig_pkg::*;
#(parameter int N_CH = 4) (
  // clock, reset, stream
  input wire logic            ref_clk_i,
  input wire logic            rst_i,
  input wire logic            run_i,
  input wire logic            smp_valid_i,
  // setup and inputs
  input wire ch_cfg_t [N_CH-1:0] ch_cfg_i,
  input wire rec_cfg_t        rec_cfg_i,
  input wire logic            ext_trig_i,
  input wire logic            alarm_chain_i,
  // results
  input wire logic [N_CH-1:0] ch_trig_o,
  input wire logic [N_CH-1:0] qual_armed_o,
  input wire logic            rec_trig_o,
  input wire logic            share_trig_o,
  input wire logic            ext_trig_o,
  input wire logic            alarm_o
);
  logic            q_ok;
  logic [N_CH-1:0] tmask;
  always_comb begin
    q_ok = 1'b1;
    for (int c = 0; c < N_CH; c++) begin
      tmask[c] = ch_cfg_i[c].mode inside {MODE_BASIC, MODE_DUAL};
      if (ch_cfg_i[c].mode inside {MODE_QUAL_1, MODE_QUAL_2} && !qual_armed_o[c]) q_ok = 1'b0;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence chan_fire;
    (ch_trig_o != '0) ##0 (q_ok && run_i);
  endsequence
  sequence ext_edge;
    run_i && rec_cfg_i.ext_in_en
      && (rec_cfg_i.ext_in_falling ? $fell(ext_trig_i) : $rose(ext_trig_i));
  endsequence
  a_share_follows_rec: assert property (share_trig_o == rec_trig_o)
    else $error("share out differs");
  a_chan_to_rec: assert property (chan_fire |=> rec_trig_o)
    else $error("channel fire lost");
  a_qual_blocks_rec: assert property (!q_ok |=> !rec_trig_o)
    else $error("rec fired while unqualified");
  a_ext_in_edge: assert property (ext_edge ##0 q_ok |=> rec_trig_o)
    else $error("ext edge lost");
  a_ext_out_level: assert property (ext_trig_o == (($past(rec_trig_o) && $past(rec_cfg_i.ext_out_en))
    ^ rec_cfg_i.ext_out_active_low))
    else $error("ext out wrong");
  a_chain_alarm: assert property (alarm_chain_i |=> alarm_o)
    else $error("alarm chain lost");
  a_pulse_single: assert property (ch_trig_o != '0 |=> (ch_trig_o & $past(ch_trig_o)) == '0)
    else $error("channel pulse too long");
  a_stream_quiet: assert property (!run_i || !smp_valid_i |=> ch_trig_o == '0)
    else $error("fire without sample");
  a_mode_quiet: assert property ((ch_trig_o & ~$past(tmask)) == '0)
    else $error("non-trigger channel fired");
endmodule // trig_properties
`default_nettype wire

/* tb/adc_stream.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_stream
  import trig_pkg::*;
#(parameter int N_CH = 4) (
  // clock
  input  wire logic ref_clk_i,
  // stream towards the block
  output var logic  run_o,
  output var logic  valid_o,
  output var logic signed [N_CH-1:0][SAMPLE_W-1:0] smp_o
);
  initial begin
    run_o = 1'b0;
    valid_o = 1'b0;
    smp_o = '0;
  end
  task automatic put(input int a, input int b);
    @(posedge ref_clk_i);
    valid_o <= 1'b1;
    for (int c = 0; c < N_CH; c++) smp_o[c] <= 16'(c == 1 ? b : a);
  endtask
  // no sample: lines flip every cycle
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      valid_o <= 1'b0;
      smp_o <= ~smp_o;
    end
  endtask
  task automatic rearm();
    @(posedge ref_clk_i);
    run_o <= 1'b0;
    idle(2);
    run_o <= 1'b1;
  endtask
endmodule // adc_stream
`default_nettype wire

/* tb/channel_trigger_and_alarm_logic_test.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_trigger_and_alarm_logic_test;
  import trig_pkg::*;
  localparam int N = 4;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, ext_trig_i = 1'b0, share_trig_i = 1'b0, alarm_chain_i = 1'b0;
  logic run_i, smp_valid_i, rec_trig_o, share_trig_o, ext_trig_o, alarm_o;
  logic signed [N-1:0][SAMPLE_W-1:0] smp_i;
  ch_cfg_t [N-1:0] ch_cfg_i = '0;
  rec_cfg_t        rec_cfg_i = '0;
  logic [N-1:0]    ch_trig_o, qual_armed_o;
  int error_cnt = 0, total_checks = 0;
  int cnt[6] = '{default: 0};
  int b[6];
  always #12.5 ref_clk_i = ~ref_clk_i;
  chan_trigger #(.N_CH(N)) DUT (.ref_clk_i, .rst_i, .run_i, .smp_valid_i, .smp_i, .ch_cfg_i,
    .rec_cfg_i, .ext_trig_i, .share_trig_i, .alarm_chain_i, .ch_trig_o, .qual_armed_o,
    .rec_trig_o, .share_trig_o, .ext_trig_o, .alarm_o);
  adc_stream #(.N_CH(N)) src (.ref_clk_i, .run_o(run_i), .valid_o(smp_valid_i), .smp_o(smp_i));
  // event counters: ch0, ch1, rec, ext active, alarm, share
  always @(posedge ref_clk_i) if (!rst_i) begin
    cnt[0] += int'(ch_trig_o[0] === 1'b1);
    cnt[1] += int'(ch_trig_o[1] === 1'b1);
    cnt[2] += int'(rec_trig_o === 1'b1);
    cnt[3] += int'(ext_trig_o !== rec_cfg_i.ext_out_active_low);
    cnt[4] += int'(alarm_o === 1'b1);
    cnt[5] += int'(share_trig_o === 1'b1);
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input int i, input int exp);
    total_checks++;
    if (cnt[i] - b[i] !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: counter %0d got %0d", $time, i, cnt[i] - b[i]);
    end
  endtask
  task automatic mark();
    @(negedge ref_clk_i);
    b = cnt;
  endtask
  task automatic cfg(input int c, input ch_mode_t m, input logic d, input int p, s, h);
    @(posedge ref_clk_i);
    ch_cfg_i[c] <= '{m, d, 16'(p), 16'(s), 16'(h)};
  endtask
  task automatic seq(input int v[$], input int c1);
    src.rearm();
    mark();
    foreach (v[i]) src.put(v[i], c1);
    src.idle(6);
    @(negedge ref_clk_i);
  endtask
  task automatic tick(input int n, input bit chain, input logic v);
    @(posedge ref_clk_i);
    if (chain) alarm_chain_i <= v;
    else share_trig_i <= v;
    repeat (n) @(posedge ref_clk_i);
    if (chain) alarm_chain_i <= ~v;
    else share_trig_i <= ~v;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_levels();
    cfg(0, MODE_BASIC, 1'b0, 100, 0, 10);
    seq('{150, 80, 100, 101, 95, 120, 89, 101}, 0);
    check(0, 2);
    check(2, 2);
    cfg(0, MODE_BASIC, 1'b1, -50, 0, 5);
    seq('{-40, -50, -51, -52}, 0);
    check(0, 1);
    cfg(0, MODE_DUAL, 1'b0, 100, -100, 10);
    seq('{0, 101, 95, 101, 0, -101, -95, -101}, 0);
    check(0, 2);
    cfg(0, MODE_DUAL, 1'b1, 100, -100, 10);
    seq('{0, 120, 50, -120, -50}, 0);
    check(0, 2);
    $display("levels test done");
  endtask
  task automatic t_qual();
    cfg(0, MODE_BASIC, 1'b0, 100, 0, 10);
    for (int i = 0; i < 4; i++) begin
      cfg(1, i < 2 ? MODE_QUAL_1 : MODE_QUAL_2, 1'b0, i < 2 ? 0 : 50, -50, 0);
      seq('{80, 101}, i[0] ? (i < 2 ? 5 : -60) : 0);
      check(2, i % 2);
      check(1, 0);
    end
    cfg(1, MODE_OFF, 1'b0, 0, 0, 0);
    $display("qualifier test done");
  endtask
  task automatic t_ext();
    cfg(0, MODE_OFF, 1'b0, 0, 0, 0);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk_i);
      rec_cfg_i <= '{i < 4, i > 1, 1'b1, 1'b0};
      repeat (4) @(posedge ref_clk_i);
      mark();
      @(posedge ref_clk_i);
      ext_trig_i <= ~ext_trig_i;
      repeat (6) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check(2, int'(i == 0 || i == 3));
      check(3, int'(i == 0 || i == 3));
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk_i);
      rec_cfg_i <= '{1'b0, 1'b0, i == 0, 1'b1};
      repeat (4) @(posedge ref_clk_i);
      mark();
      tick(1, 1'b0, 1'b1);
      check(2, 1);
      check(5, 1);
      check(3, 1 - i);
    end
    $display("external test done");
  endtask
  task automatic t_alarm();
    cfg(0, MODE_ALARM_1, 1'b0, 100, 0, 0);
    seq('{50, 120, 120, 120, 120, 120, 50}, 0);
    check(4, 5);
    check(0, 0);
    cfg(0, MODE_ALARM_2, 1'b0, 100, -100, 0);
    seq('{0, -120, -120, -120, 0, 130, 0}, 0);
    check(4, 4);
    mark();
    tick(4, 1'b1, 1'b1);
    check(4, 4);
    $display("alarm test done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_levels();
    t_qual();
    t_ext();
    t_alarm();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    $display("unexpected at %0t: run hung", $time);
    complete_run();
  end
endmodule // channel_trigger_and_alarm_logic_test
bind chan_trigger trig_properties #(.N_CH(N_CH)) chk (.ref_clk_i, .rst_i, .run_i, .smp_valid_i,
  .ch_cfg_i, .rec_cfg_i, .ext_trig_i, .alarm_chain_i, .ch_trig_o, .qual_armed_o, .rec_trig_o,
  .share_trig_o, .ext_trig_o, .alarm_o);
`default_nettype wire
